// ==== shared/kopc_cfg.svh ====
// Register indices, field positions, reset values and key constants
`ifndef KOPC_CFG_SVH
`define KOPC_CFG_SVH

`define KOPC_KEY_IDX        16'h4008
`define KOPC_SCRATCH_IDX    16'h4009
`define KOPC_CTRL_IDX       16'h400A
`define KOPC_STATUS_IDX     16'h400B

`define KOPC_UNLOCK_VALUE   16'h9716
`define KOPC_KEY_RESET      16'h0000
`define KOPC_SCRATCH_RESET  16'h0000

`define KOPC_PROG_BIT       15
`define KOPC_TARGET_BIT     13
`define KOPC_FINAL_BIT      11
`define KOPC_VERIFY_BIT     10
`define KOPC_WRITE_BIT      9
`define KOPC_READ_BIT       8
`define KOPC_MARGIN_HI      7
`define KOPC_MARGIN_LO      6
`define KOPC_ALL_PAGES_BIT  5
`define KOPC_PAGE_HI        1
`define KOPC_PAGE_LO        0

`define KOPC_TARGET_RESET   1'b1
`define KOPC_MARGIN_RESET   2'h0
`define KOPC_PAGE_RESET     2'h0

`define KOPC_MARGIN_NORMAL  2'h0
`define KOPC_MARGIN_RSVD    2'h1
`define KOPC_VOL_PAGE_RSVD  2'h3
`define KOPC_VOL_PAGE_BASE  3'h2

`define KOPC_ST_BUSY_BIT    0
`define KOPC_ST_FINAL_BIT   1
`define KOPC_ST_REJECT_BIT  2
`define KOPC_ST_FAIL_BIT    3
`define KOPC_ST_UNLOCK_BIT  4
`define KOPC_ST_PROG_BIT    5

`endif

// ==== shared/kopc_pkg.sv ====
// Types shared by the keyed program control block
package kopc_pkg;

   typedef enum logic [2:0] {
      op_none,
      op_read,
      op_write,
      op_verify,
      op_final
   } kopc_op_e;

   typedef enum logic [1:0] {
      st_idle,
      st_issue,
      st_wait
   } kopc_state_e;

   typedef struct packed {
      logic [15:0] key;
      logic [15:0] scratch;
      logic        program_state_select;
      logic        otp_target;
      logic [1:0]  read_margin_level;
      logic        all_pages_select;
      logic [1:0]  page_sel;
      logic        finalised;
      logic        reject_flag;
      logic        fail_flag;
      kopc_state_e state;
      kopc_op_e    cmd_op;
      logic        cmd_otp;
      logic        cmd_all;
      logic [2:0]  cmd_page;
      logic [1:0]  cmd_margin;
      logic [31:0] prdata;
   } kopc_regs_s;

endpackage

// ==== rtl/kopc_cmd_issue.sv ====
// Command decode: picks one operation, maps the page and screens it
`timescale 1ns/1ns
`include "kopc_cfg.svh"

module kopc_cmd_issue (
   input  wire logic              cmd_final,
   input  wire logic              cmd_verify,
   input  wire logic              cmd_write,
   input  wire logic              cmd_read,
   input  wire logic              otp_target,
   input  wire logic              all_pages,
   input  wire logic [1:0]        page_sel,
   input  wire logic [1:0]        margin,
   input  wire logic              finalised,
   output kopc_pkg::kopc_op_e     op,
   output logic      [2:0]        phys_page,
   output logic                   reject
);

   logic [2:0] n_cmds;

   always_comb begin
      n_cmds = {2'h0, cmd_final} + {2'h0, cmd_verify}
             + {2'h0, cmd_write} + {2'h0, cmd_read};
      // Finalise outranks verify, write and read if several are set
      if (cmd_final) begin
         op = kopc_pkg::op_final;
      end else if (cmd_verify) begin
         op = kopc_pkg::op_verify;
      end else if (cmd_write) begin
         op = kopc_pkg::op_write;
      end else if (cmd_read) begin
         op = kopc_pkg::op_read;
      end else begin
         op = kopc_pkg::op_none;
      end
      if (otp_target) begin
         phys_page = {1'b0, page_sel};
      end else begin
         phys_page = `KOPC_VOL_PAGE_BASE + {1'b0, page_sel};
      end
      reject = 1'b0;
      if (n_cmds > 3'h1) begin
         reject = 1'b1;
      end
      if (!all_pages && !otp_target && page_sel == `KOPC_VOL_PAGE_RSVD) begin
         reject = 1'b1;
      end
      if ((cmd_read || cmd_verify) && margin == `KOPC_MARGIN_RSVD) begin
         reject = 1'b1;
      end
      // No OTP programming once finalised
      if (finalised && otp_target && (cmd_write || cmd_final)) begin
         reject = 1'b1;
      end
   end

endmodule

// ==== rtl/kopc_top.sv ====
// Keyed access and program control of the nonvolatile memories over APB
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "kopc_cfg.svh"

module kopc_top (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [17:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     program_mode,
   output logic                     mem_cmd_valid,
   input  wire logic                mem_cmd_ready,
   output kopc_pkg::kopc_op_e       mem_cmd_op,
   output logic                     mem_cmd_otp,
   output logic                     mem_cmd_all,
   output logic      [2:0]          mem_cmd_page,
   output logic      [1:0]          mem_cmd_margin,
   input  wire logic                mem_cmd_done,
   input  wire logic                mem_cmd_fail
);

   kopc_pkg::kopc_regs_s r;
   kopc_pkg::kopc_regs_s next_r;

   logic                 unlocked;
   logic                 mapped;
   logic                 wr_en;
   logic                 rd_setup;
   logic                 ctrl_wr;
   logic                 any_cmd;
   kopc_pkg::kopc_op_e   dec_op;
   logic [2:0]           dec_page;
   logic                 dec_reject;
   logic                 tgt_eff;
   logic [1:0]           margin_eff;

   // True when the byte address is the word-aligned address of a register index
   function automatic logic reg_hit(input logic [17:0] addr,
                                    input logic [15:0] idx);
      reg_hit = (addr == {idx, 2'b00});
   endfunction

   function automatic logic [31:0] read_mux(input logic [17:0] addr,
                                            input kopc_pkg::kopc_regs_s s,
                                            input logic unl);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (reg_hit(addr, `KOPC_KEY_IDX)) begin
         v[15:0] = s.key;
      end else if (reg_hit(addr, `KOPC_SCRATCH_IDX)) begin
         v[15:0] = s.scratch;
      end else if (reg_hit(addr, `KOPC_CTRL_IDX)) begin
         // Command bits are actions and read back as zero
         v[`KOPC_PROG_BIT]                     = s.program_state_select;
         v[`KOPC_TARGET_BIT]                   = s.otp_target;
         v[`KOPC_MARGIN_HI:`KOPC_MARGIN_LO]    = s.read_margin_level;
         v[`KOPC_ALL_PAGES_BIT]                = s.all_pages_select;
         v[`KOPC_PAGE_HI:`KOPC_PAGE_LO]        = s.page_sel;
      end else if (reg_hit(addr, `KOPC_STATUS_IDX)) begin
         v[`KOPC_ST_BUSY_BIT]   = (s.state != kopc_pkg::st_idle);
         v[`KOPC_ST_FINAL_BIT]  = s.finalised;
         v[`KOPC_ST_REJECT_BIT] = s.reject_flag;
         v[`KOPC_ST_FAIL_BIT]   = s.fail_flag;
         v[`KOPC_ST_UNLOCK_BIT] = unl;
         v[`KOPC_ST_PROG_BIT]   = s.program_state_select;
      end
      read_mux = v;
   endfunction

   assign unlocked = (r.key == `KOPC_UNLOCK_VALUE);
   assign mapped   = reg_hit(paddr, `KOPC_KEY_IDX)
                   | reg_hit(paddr, `KOPC_SCRATCH_IDX)
                   | reg_hit(paddr, `KOPC_CTRL_IDX)
                   | reg_hit(paddr, `KOPC_STATUS_IDX);

   // Zero wait states; unmapped words answer with an error
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign wr_en    = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign ctrl_wr  = wr_en & reg_hit(paddr, `KOPC_CTRL_IDX);

   assign any_cmd  = pwdata[`KOPC_FINAL_BIT] | pwdata[`KOPC_VERIFY_BIT]
                   | pwdata[`KOPC_WRITE_BIT] | pwdata[`KOPC_READ_BIT];

   // A command uses the target and margin written in the same access
   assign tgt_eff    = unlocked ? pwdata[`KOPC_TARGET_BIT] : r.otp_target;
   assign margin_eff = unlocked ? pwdata[`KOPC_MARGIN_HI:`KOPC_MARGIN_LO]
                                : r.read_margin_level;

   kopc_cmd_issue u_issue (
      .cmd_final  (pwdata[`KOPC_FINAL_BIT]),
      .cmd_verify (pwdata[`KOPC_VERIFY_BIT]),
      .cmd_write  (pwdata[`KOPC_WRITE_BIT]),
      .cmd_read   (pwdata[`KOPC_READ_BIT]),
      .otp_target (tgt_eff),
      .all_pages  (pwdata[`KOPC_ALL_PAGES_BIT]),
      .page_sel   (pwdata[`KOPC_PAGE_HI:`KOPC_PAGE_LO]),
      .margin     (margin_eff),
      .finalised  (r.finalised),
      .op         (dec_op),
      .phys_page  (dec_page),
      .reject     (dec_reject)
   );

   always_comb begin
      next_r = r;

      if (rd_setup) begin
         next_r.prdata = read_mux(paddr, r, unlocked);
      end

      if (wr_en && reg_hit(paddr, `KOPC_KEY_IDX)) begin
         next_r.key = pwdata[15:0];
      end

      if (wr_en && reg_hit(paddr, `KOPC_SCRATCH_IDX)) begin
         next_r.scratch = pwdata[15:0];
      end

      // Software clears the reject and fail flags by writing one; a new event wins
      if (wr_en && reg_hit(paddr, `KOPC_STATUS_IDX)) begin
         if (pwdata[`KOPC_ST_REJECT_BIT]) begin
            next_r.reject_flag = 1'b0;
         end
         if (pwdata[`KOPC_ST_FAIL_BIT]) begin
            next_r.fail_flag = 1'b0;
         end
      end

      if (ctrl_wr) begin
         // Scope and page stay writable without the key
         next_r.all_pages_select = pwdata[`KOPC_ALL_PAGES_BIT];
         next_r.page_sel = pwdata[`KOPC_PAGE_HI:`KOPC_PAGE_LO];
         if (unlocked) begin
            if (pwdata[`KOPC_PROG_BIT]) begin
               next_r.program_state_select = 1'b1;
            end
            next_r.otp_target = pwdata[`KOPC_TARGET_BIT];
            next_r.read_margin_level =
               pwdata[`KOPC_MARGIN_HI:`KOPC_MARGIN_LO];
            if (any_cmd) begin
               if (r.state != kopc_pkg::st_idle || dec_reject) begin
                  next_r.reject_flag = 1'b1;
               end else begin
                  next_r.state      = kopc_pkg::st_issue;
                  next_r.cmd_op     = dec_op;
                  next_r.cmd_otp    = tgt_eff;
                  next_r.cmd_all    = pwdata[`KOPC_ALL_PAGES_BIT];
                  next_r.cmd_page   = dec_page;
                  next_r.cmd_margin = margin_eff;
               end
            end
         end
      end

      case (r.state)
         kopc_pkg::st_idle: begin
         end
         kopc_pkg::st_issue: begin
            if (mem_cmd_ready) begin
               next_r.state = kopc_pkg::st_wait;
            end
         end
         kopc_pkg::st_wait: begin
            if (mem_cmd_done) begin
               next_r.state = kopc_pkg::st_idle;
               if (mem_cmd_fail) begin
                  next_r.fail_flag = 1'b1;
               end else if (r.cmd_op == kopc_pkg::op_final) begin
                  next_r.finalised = 1'b1;
               end
            end
         end
         default: begin
            next_r.state = kopc_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.key                  <= `KOPC_KEY_RESET;
         r.scratch              <= `KOPC_SCRATCH_RESET;
         r.program_state_select <= 1'b0;
         r.otp_target           <= `KOPC_TARGET_RESET;
         r.read_margin_level    <= `KOPC_MARGIN_RESET;
         r.all_pages_select     <= 1'b0;
         r.page_sel             <= `KOPC_PAGE_RESET;
         r.finalised            <= 1'b0;
         r.reject_flag          <= 1'b0;
         r.fail_flag            <= 1'b0;
         r.state                <= kopc_pkg::st_idle;
         r.cmd_op               <= kopc_pkg::op_none;
         r.cmd_otp              <= 1'b0;
         r.cmd_all              <= 1'b0;
         r.cmd_page             <= 3'h0;
         r.cmd_margin           <= 2'h0;
         r.prdata               <= 32'h0000_0000;
      end else begin
         r <= next_r;
      end
   end

   assign prdata         = r.prdata;
   assign program_mode   = r.program_state_select;
   assign mem_cmd_valid  = (r.state == kopc_pkg::st_issue);
   assign mem_cmd_op     = r.cmd_op;
   assign mem_cmd_otp    = r.cmd_otp;
   assign mem_cmd_all    = r.cmd_all;
   assign mem_cmd_page   = r.cmd_page;
   assign mem_cmd_margin = r.cmd_margin;

endmodule

// ==== verif/kopc_top_assertions.sv ====
// Port checker for the keyed program control block
`timescale 1ns/1ns
`include "kopc_cfg.svh"
module kopc_top_assertions (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [17:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               program_mode,
   input wire logic               mem_cmd_valid,
   input wire logic               mem_cmd_ready,
   input wire kopc_pkg::kopc_op_e mem_cmd_op,
   input wire logic               mem_cmd_otp,
   input wire logic               mem_cmd_all,
   input wire logic [2:0]         mem_cmd_page,
   input wire logic [1:0]         mem_cmd_margin
);
   localparam logic [17:0] ctl_a = {`KOPC_CTRL_IDX, 2'h0};
   localparam logic [17:0] key_a = {`KOPC_KEY_IDX, 2'h0};
   logic       key_ok;
   logic       ctrl_wr;
   logic       acc_wr;
   logic       keyed_wr;
   logic       prog_req;
   logic [1:0] wr_margin;
   logic [1:0] wr_page;
   logic       wr_target;
   logic       wr_all;
   assign acc_wr    = psel && penable && pwrite;
   assign ctrl_wr   = acc_wr && paddr == ctl_a;
   assign keyed_wr  = ctrl_wr && key_ok;
   assign prog_req  = keyed_wr && pwdata[`KOPC_PROG_BIT];
   assign wr_margin = pwdata[`KOPC_MARGIN_HI:`KOPC_MARGIN_LO];
   assign wr_page   = pwdata[`KOPC_PAGE_HI:`KOPC_PAGE_LO];
   assign wr_target = pwdata[`KOPC_TARGET_BIT];
   assign wr_all    = pwdata[`KOPC_ALL_PAGES_BIT];
   // Mirrors whether the key register holds the unlock value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_ok <= 1'b0;
      end else if (acc_wr && paddr == key_a) begin
         key_ok <= pwdata[15:0] == `KOPC_UNLOCK_VALUE;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_keyed_read;
      keyed_wr && pwdata[`KOPC_FINAL_BIT:`KOPC_READ_BIT] == 4'h1;
   endsequence
   sequence s_read_issue;
      s_keyed_read ##1 $rose(mem_cmd_valid);
   endsequence
   chk_prog_sticky: assert property (program_mode |=> program_mode)
      else $error("program state dropped");
   chk_prog_keyed: assert property ($rose(program_mode) |->
      $past(prog_req)) else $error("bad program entry");
   chk_cmd_keyed: assert property ($rose(mem_cmd_valid) |->
      $past(keyed_wr)) else $error("command without key");
   chk_cmd_hold: assert property (
      mem_cmd_valid && !mem_cmd_ready |=>
      mem_cmd_valid && $stable(mem_cmd_op) && $stable(mem_cmd_page))
      else $error("command not held");
   chk_read_op: assert property (s_read_issue |->
      mem_cmd_op == kopc_pkg::op_read && mem_cmd_margin == $past(wr_margin))
      else $error("read command wrong");
   chk_read_target: assert property (s_read_issue |->
      mem_cmd_otp == $past(wr_target) && mem_cmd_all == $past(wr_all))
      else $error("target or scope wrong");
   chk_margin_legal: assert property (mem_cmd_valid &&
      mem_cmd_op inside {kopc_pkg::op_read, kopc_pkg::op_verify} |->
      mem_cmd_margin != `KOPC_MARGIN_RSVD)
      else $error("reserved margin issued");
   chk_vol_page: assert property (
      mem_cmd_valid && !mem_cmd_otp && !mem_cmd_all |->
      mem_cmd_page inside {3'h2, 3'h3, 3'h4})
      else $error("volatile page wrong");
   chk_otp_page: assert property (
      s_read_issue ##0 (mem_cmd_otp && !mem_cmd_all) |->
      mem_cmd_page == {1'b0, $past(wr_page)}) else $error("otp page wrong");
endmodule

bind kopc_top kopc_top_assertions u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .program_mode(program_mode), .mem_cmd_valid(mem_cmd_valid),
   .mem_cmd_ready(mem_cmd_ready), .mem_cmd_op(mem_cmd_op),
   .mem_cmd_otp(mem_cmd_otp), .mem_cmd_all(mem_cmd_all),
   .mem_cmd_page(mem_cmd_page), .mem_cmd_margin(mem_cmd_margin));

// ==== verif/kopc_top_test.sv ====
// Directed test of the keyed program control block
`timescale 1ns/1ns
`include "kopc_cfg.svh"
module kopc_top_test;
   localparam logic [17:0] key_a = {`KOPC_KEY_IDX, 2'h0};
   localparam logic [17:0] scr_a = {`KOPC_SCRATCH_IDX, 2'h0};
   localparam logic [17:0] ctl_a = {`KOPC_CTRL_IDX, 2'h0};
   localparam logic [17:0] sts_a = {`KOPC_STATUS_IDX, 2'h0};
   localparam logic [15:0] rej [4] = '{16'h0103, 16'h2140, 16'h2300, 16'h2200};
   logic               pclk = 1'b0;
   logic               presetn, psel, penable, pwrite, last_err;
   logic [17:0]        paddr;
   logic [31:0]        pwdata, prdata, rdata;
   logic               pready, pslverr, program_mode, mem_cmd_valid;
   logic               mem_cmd_ready = 1'b0;
   logic               mem_cmd_done = 1'b0;
   logic               mem_cmd_otp, mem_cmd_all, mem_cmd_fail;
   logic [2:0]         mem_cmd_page;
   logic [1:0]         mem_cmd_margin;
   logic [9:0]         got = '0;
   kopc_pkg::kopc_op_e mem_cmd_op;
   int                 err_count = 0;
   int                 checks = 0;
   int                 issued = 0;
   int                 cycles = 0;
   int                 n;
   kopc_top u_kopc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .program_mode(program_mode), .mem_cmd_valid(mem_cmd_valid),
      .mem_cmd_ready(mem_cmd_ready), .mem_cmd_op(mem_cmd_op),
      .mem_cmd_otp(mem_cmd_otp), .mem_cmd_all(mem_cmd_all),
      .mem_cmd_page(mem_cmd_page), .mem_cmd_margin(mem_cmd_margin),
      .mem_cmd_done(mem_cmd_done), .mem_cmd_fail(mem_cmd_fail));
   always #10 pclk = ~pclk;
   // Memory side: accepts one cycle after offer, finishes one cycle later
   always @(posedge pclk) begin
      mem_cmd_ready <= mem_cmd_valid && !mem_cmd_ready;
      mem_cmd_done <= mem_cmd_ready;
      if (mem_cmd_valid && mem_cmd_ready) begin
         issued <= issued + 1;
         got <= {mem_cmd_otp, mem_cmd_all, mem_cmd_page, mem_cmd_margin,
                 mem_cmd_op};
      end
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         $display("CHECK FAILED at %0t: timeout", $time);
         end_of_test();
      end
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic [17:0] a, input logic w,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      cmp(rdata & m, e);
   endtask
   task automatic cmd(input logic [15:0] w, input logic [9:0] e);
      n = issued;
      wr(ctl_a, {16'h0, w});
      repeat (4) @(posedge pclk);
      cmp(32'(issued - n), 32'h1);
      cmp({22'h0, got}, {22'h0, e});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, mem_cmd_fail} = 5'h0;
      {paddr, pwdata} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(key_a, 32'hFFFFFFFF, 32'h0);
      rd(ctl_a, 32'hFFFFFFFF, 32'h2000);
      wr(scr_a, 32'h0000A5C3);
      rd(scr_a, 32'hFFFFFFFF, 32'hA5C3);
      apb(18'h10040, 1'b0, 32'h0);
      cmp({31'h0, last_err}, 32'h1);
      wr(ctl_a, 32'h8123);
      repeat (4) @(posedge pclk);
      cmp(32'(issued), 32'h0);
      rd(ctl_a, 32'hFFFF, 32'h2023);
      wr(key_a, 32'h9717);
      wr(ctl_a, 32'h8000);
      cmp({31'h0, program_mode}, 32'h0);
      wr(key_a, 32'h9716);
      rd(sts_a, 32'h10, 32'h10);
      cmd(16'h0100, {2'b00, 3'h2, 2'h0, kopc_pkg::op_read});
      cmd(16'h0201, {2'b00, 3'h3, 2'h0, kopc_pkg::op_write});
      cmd(16'h0482, {2'b00, 3'h4, 2'h2, kopc_pkg::op_verify});
      cmd(16'h21C3, {2'b10, 3'h3, 2'h3, kopc_pkg::op_read});
      cmd(16'h2220, {2'b11, 3'h0, 2'h0, kopc_pkg::op_write});
      cmd(16'h2800, {2'b10, 3'h0, 2'h0, kopc_pkg::op_final});
      rd(sts_a, 32'h2, 32'h2);
      foreach (rej[i]) begin
         n = issued;
         wr(ctl_a, {16'h0, rej[i]});
         repeat (4) @(posedge pclk);
         cmp(32'(issued - n), 32'h0);
         rd(sts_a, 32'h4, 32'h4);
         wr(sts_a, 32'h4);
      end
      rd(sts_a, 32'h4, 32'h0);
      // A failing command sets the fail flag and leaves finalise alone
      mem_cmd_fail <= 1'b1;
      cmd(16'h0100, {2'b00, 3'h2, 2'h0, kopc_pkg::op_read});
      mem_cmd_fail <= 1'b0;
      rd(sts_a, 32'hA, 32'hA);
      wr(sts_a, 32'h8);
      rd(sts_a, 32'h8, 32'h0);
      // Second command while the first is still busy is refused
      n = issued;
      wr(ctl_a, 32'h0100);
      wr(ctl_a, 32'h0100);
      repeat (4) @(posedge pclk);
      cmp(32'(issued - n), 32'h1);
      rd(sts_a, 32'h4, 32'h4);
      wr(sts_a, 32'h4);
      wr(ctl_a, 32'h8000);
      cmp({31'h0, program_mode}, 32'h1);
      wr(ctl_a, 32'h0);
      cmp({31'h0, program_mode}, 32'h1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp({31'h0, program_mode}, 32'h0);
      rd(key_a, 32'hFFFFFFFF, 32'h0);
      end_of_test();
   end
endmodule
